// file: hdl/serp_defs.svh
// constants shared by both ends of the serial eeprom read path
// assumes a 20 MHz core clock on the controller end
`ifndef SERP_DEFS_SVH
`define SERP_DEFS_SVH
`define SERP_ADDR_W 14
`define SERP_DEV_PREFIX 4'hA
`define SERP_CORE_MHZ 20
`define SERP_POWER_DELAY_US 100
`define SERP_POWER_DELAY_CYC (`SERP_POWER_DELAY_US * `SERP_CORE_MHZ)
`define SERP_BUS_FREE_NS 1300
`define SERP_BUS_FREE_CYC ((`SERP_BUS_FREE_NS * `SERP_CORE_MHZ + 999) / 1000)
`define SERP_SCL_DIV 10
`endif

// file: hdl/serp_pkg.sv
// types shared by the eeprom target and the bus controller
// assumes nothing beyond a systemverilog compiler
package serp_pkg;
  typedef enum logic [2:0] {
    dev_idle = 3'h0,
    dev_devaddr = 3'h1,
    dev_addrhi = 3'h2,
    dev_addrlo = 3'h3,
    dev_wdata = 3'h4,
    dev_read = 3'h5
  } serp_dev_state_type;
  typedef enum logic [2:0] {
    host_por = 3'h0,
    host_idle = 3'h1,
    host_start = 3'h2,
    host_bit = 3'h3,
    host_stop = 3'h4,
    host_free = 3'h5
  } serp_host_state_type;
  typedef enum logic {
    read_current = 1'b0,
    read_random = 1'b1
  } serp_read_kind_type;
endpackage

// file: hdl/serp_link_if.sv
// two-wire link between the bus controller and the eeprom target
// the pull-up is modelled here: the line is low while any enabled driver pulls low
`timescale 1ns/100ps
interface serp_link_if;
  logic scl;
  logic sda_host_o;
  logic sda_host_oe;
  logic sda_dev_o;
  logic sda_dev_oe;
  logic sda;

  // open-drain wired-and with an external pull-up
  assign sda = ~((sda_host_oe & ~sda_host_o) | (sda_dev_oe & ~sda_dev_o));

  modport host (output scl, output sda_host_o, output sda_host_oe, input sda);
  modport dev (input scl, input sda, output sda_dev_o, output sda_dev_oe);
endinterface

// file: hdl/serp_device.sv
// eeprom target end: read path of a 16k byte two-wire serial memory
// assumes the link clock comes from the controller and stands still between frames;
// the array is filled from the core clock side through the load port
// Behaviour
// - falling data with clock high starts a command
// - rising data with clock high stops a command
// - acknowledge only when select bits match pins
// - byte address and counter are 14 bits
// - read uses direction bit set to one
// - counter holds last address plus one
// - matching read address: ack, then send byte
// - counter increments after each byte sent
// - controller leaves ack high to end read
// - nack then stop: release bus, standby
// - controller ack asks for next byte
// - bytes continue while controller keeps acknowledging
// - counter wraps from top to address zero
// - controller ends sequential read with nack, stop
// - dummy write loads counter from two bytes
// - new start drops pending write, runs read
// - commands ignored until power-on reset releases
// - controller waits 100 us after power-up
// - controller keeps bus free between stop, start
`include "serp_defs.svh"
`timescale 1ns/100ps
module serp_device #(
  parameter int ADDR_W = `SERP_ADDR_W
) (
  serp_link_if.dev link,
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [2:0] chip_select_pins,
  input wire logic load_valid,
  input wire logic [ADDR_W-1:0] load_addr,
  input wire logic [7:0] load_data,
  output logic link_busy
);
  import serp_pkg::*;
  localparam int DEPTH = 2 ** ADDR_W;
  localparam int HI_W = ADDR_W - 8;
  // the high address byte carries at most eight useful bits
  if (ADDR_W < 9 || ADDR_W > 16)
  begin : g_bad_width
    $error("serp_device: ADDR_W must lie in 9..16");
  end
  logic [7:0] mem [DEPTH];
  serp_dev_state_type state_q, state_d;
  serp_dev_state_type pend_q, pend_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] out_q, out_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [HI_W-1:0] hi_q, hi_d;
  logic [2:0] cs_meta_q, cs_q;
  logic start_tog_q, start_tog_d, stop_tog_q, stop_tog_d, start_seen_q, start_seen_d, stop_seen_q, stop_seen_d;
  logic ack_q, ack_d, busy_src_q, busy_src_d, oe_q, oe_d, busy_meta_q, busy_q;
  logic [7:0] byte_in, rd_byte;

  // start and stop are the only data edges that happen with the clock high
  always_comb
  begin
    start_tog_d = start_tog_q;
    stop_tog_d = stop_tog_q;
    if (link.scl)
    begin
      start_tog_d = ~start_tog_q;
      stop_tog_d = ~stop_tog_q;
    end
  end

  // sda acts as a clock here; the protocol keeps these edges apart from scl edges
  always_ff @(negedge link.sda or negedge reset_n)
  begin
    if (!reset_n)
      start_tog_q <= 1'b0;
    else
      start_tog_q <= start_tog_d;
  end

  always_ff @(posedge link.sda or negedge reset_n)
  begin
    if (!reset_n)
      stop_tog_q <= 1'b0;
    else
      stop_tog_q <= stop_tog_d;
  end

  // array read is asynchronous so the byte is ready at the ack edge
  assign rd_byte = mem[addr_q];
  assign byte_in = {shift_q[6:0], link.sda};

  // protocol state, advanced on each rising link clock
  always_comb
  begin
    state_d = state_q;
    pend_d = pend_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    out_d = out_q;
    addr_d = addr_q;
    hi_d = hi_q;
    ack_d = ack_q;
    start_seen_d = start_seen_q;
    stop_seen_d = stop_seen_q;
    if (start_tog_q != start_seen_q)
    begin
      // a fresh start overrides anything pending, including a dummy write
      start_seen_d = start_tog_q;
      stop_seen_d = stop_tog_q;
      state_d = dev_devaddr;
      cnt_d = 4'h1;
      shift_d = {7'h00, link.sda};
      ack_d = 1'b0;
    end
    else if (stop_tog_q != stop_seen_q)
    begin
      stop_seen_d = stop_tog_q;
      state_d = dev_idle;
      cnt_d = 4'h0;
      ack_d = 1'b0;
    end
    else
    begin
      case (state_q)
        dev_idle: cnt_d = 4'h0;
        dev_read:
        begin
          if (cnt_q == 4'h8)
          begin
            if (!link.sda)
            begin
              cnt_d = 4'h0;
              out_d = rd_byte;
            end
            else
              state_d = dev_idle;
          end
          else
          begin
            out_d = {out_q[6:0], 1'b0};
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == 4'h7)
              addr_d = addr_q + ADDR_W'(1);
          end
        end
        default:
        begin
          if (cnt_q == 4'h8)
          begin
            cnt_d = 4'h0;
            ack_d = 1'b0;
            state_d = ack_q ? pend_q : dev_idle;
            if (ack_q && pend_q == dev_read)
              out_d = rd_byte;
          end
          else
          begin
            shift_d = byte_in;
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == 4'h7)
            begin
              ack_d = 1'b1;
              pend_d = dev_idle;
              case (state_q)
                dev_devaddr:
                begin
                  if (byte_in[7:4] == `SERP_DEV_PREFIX && byte_in[3:1] == cs_q)
                    pend_d = byte_in[0] ? dev_read : dev_addrhi;
                  else
                    ack_d = 1'b0;
                end
                dev_addrhi:
                begin
                  hi_d = byte_in[HI_W-1:0];
                  pend_d = dev_addrlo;
                end
                dev_addrlo:
                begin
                  addr_d = {hi_q, byte_in};
                  pend_d = dev_wdata;
                end
                default:
                begin
                  // programming is not part of this path: data bytes are refused
                  ack_d = 1'b0;
                end
              endcase
            end
          end
        end
      endcase
    end
  end
  assign busy_src_d = (state_d != dev_idle);
  // reset acts as the power-on reset; no clock edges are needed to leave it
  always_ff @(posedge link.scl or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= dev_idle;
      pend_q <= dev_idle;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      out_q <= 8'hFF;
      addr_q <= '0;
      hi_q <= '0;
      ack_q <= 1'b0;
      start_seen_q <= 1'b0;
      stop_seen_q <= 1'b0;
      busy_src_q <= 1'b0;
      cs_meta_q <= 3'h0;
      cs_q <= 3'h0;
    end
    else
    begin
      state_q <= state_d;
      pend_q <= pend_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      out_q <= out_d;
      addr_q <= addr_d;
      hi_q <= hi_d;
      ack_q <= ack_d;
      start_seen_q <= start_seen_d;
      stop_seen_q <= stop_seen_d;
      busy_src_q <= busy_src_d;
      cs_meta_q <= chip_select_pins;
      cs_q <= cs_meta_q;
    end
  end

  // line drive: decided from the rising-edge state, applied on the falling edge
  always_comb
  begin
    oe_d = 1'b0;
    if (state_q == dev_read && cnt_q < 4'h8)
      oe_d = ~out_q[7];
    else if (state_q != dev_idle && state_q != dev_read && cnt_q == 4'h8 && ack_q)
      oe_d = 1'b1;
  end
  always_ff @(negedge link.scl or negedge reset_n)
  begin
    if (!reset_n)
      oe_q <= 1'b0;
    else
      oe_q <= oe_d;
  end
  assign link.sda_dev_oe = oe_q;
  assign link.sda_dev_o = 1'b0;
  // array fill port and busy flag, core clock side
  always_ff @(posedge core_clk)
  begin
    if (load_valid)
      mem[load_addr] <= load_data;
  end
  // busy crosses as a level through two flip-flops
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      busy_meta_q <= 1'b0;
      busy_q <= 1'b0;
    end
    else
    begin
      busy_meta_q <= busy_src_q;
      busy_q <= busy_meta_q;
    end
  end
  assign link_busy = busy_q;
endmodule

// file: hdl/serp_host.sv
// bus controller end: issues current, sequential and random reads
// assumes a 20 MHz core clock; the link clock is divided from it and driven out
`include "serp_defs.svh"
`timescale 1ns/100ps
module serp_host #(
  parameter int SCL_DIV = `SERP_SCL_DIV,
  parameter int POWER_CYC = `SERP_POWER_DELAY_CYC,
  parameter int FREE_CYC = `SERP_BUS_FREE_CYC
) (
  serp_link_if.host link,
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input serp_pkg::serp_read_kind_type cmd_kind,
  input wire logic [2:0] cmd_dev,
  input wire logic [`SERP_ADDR_W-1:0] cmd_addr,
  input wire logic [7:0] cmd_len,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic done,
  output logic nack
);
  import serp_pkg::*;

  localparam int DIV_W = $clog2(SCL_DIV);
  localparam int WAIT_W = $clog2(POWER_CYC + FREE_CYC + 1);

  // the sample point must trail the data change by more than the two sync stages
  if (SCL_DIV < 4 || POWER_CYC < 1 || FREE_CYC < 1)
  begin : g_bad_param
    $error("serp_host: SCL_DIV >= 4 and nonzero waits required");
  end

  serp_host_state_type state_q, state_d;
  serp_read_kind_type kind_q, kind_d;
  logic [DIV_W-1:0] div_q, div_d;
  logic [1:0] q_q, q_d;
  logic [3:0] bit_q, bit_d;
  logic [2:0] step_q, step_d;
  logic [7:0] left_q, left_d;
  logic [7:0] tx_q, tx_d;
  logic [7:0] rx_q, rx_d;
  logic ackn_q, ackn_d;
  logic [WAIT_W-1:0] wait_q, wait_d;
  logic [2:0] dev_q, dev_d;
  logic [`SERP_ADDR_W-1:0] addr_q, addr_d;
  logic scl_q, scl_d, oe_q, oe_d;
  logic ready_q, ready_d, rvalid_q, rvalid_d, done_q, done_d, nack_q, nack_d;
  logic [7:0] rdata_q, rdata_d;
  logic sda_meta_q, sda_q;
  logic tick;
  logic [1:0] drv_lead, drv_lag;

  // byte sent at each write step: 0 address write, 1-2 byte address, 3 address read
  function automatic logic [7:0] step_byte(input logic [2:0] s, input logic [2:0] dev,
                                            input logic [`SERP_ADDR_W-1:0] a);
    if (s == 3'h0)
      step_byte = {`SERP_DEV_PREFIX, dev, 1'b0};
    else if (s == 3'h1)
      step_byte = 8'(a >> 8);
    else if (s == 3'h2)
      step_byte = a[7:0];
    else
      step_byte = {`SERP_DEV_PREFIX, dev, 1'b1};
  endfunction

  // level to leave on the line in a bit slot; one means released
  function automatic logic bit_level(input logic [2:0] s, input logic [3:0] b,
                                     input logic [7:0] t, input logic [7:0] l);
    if (s == 3'h4)
      bit_level = (b == 4'h8) ? (l <= 8'h01) : 1'b1;
    else
      bit_level = (b == 4'h8) ? 1'b1 : t[7];
  endfunction

  // {scl, pull low} for each quarter of a start, bit or stop slot
  function automatic logic [1:0] drive(input serp_host_state_type st, input logic [1:0] q,
                                       input logic lvl);
    case (st)
      host_start: drive = (q == 2'h0) ? 2'b00 : (q == 2'h1) ? 2'b10 : (q == 2'h2) ? 2'b11 : 2'b01;
      host_bit: drive = {q[1], ~lvl};
      host_stop: drive = (q == 2'h0) ? 2'b01 : (q == 2'h1) ? 2'b11 : 2'b10;
      default: drive = 2'b10;
    endcase
  endfunction

  assign tick = (div_q == DIV_W'(SCL_DIV - 1));

  // command sequencer; each slot is four quarters of SCL_DIV core cycles
  always_comb
  begin
    state_d = state_q;
    kind_d = kind_q;
    div_d = (tick || state_q == host_idle || state_q == host_por || state_q == host_free)
            ? '0 : div_q + DIV_W'(1);
    q_d = q_q;
    bit_d = bit_q;
    step_d = step_q;
    left_d = left_q;
    tx_d = tx_q;
    rx_d = rx_q;
    ackn_d = ackn_q;
    wait_d = wait_q;
    dev_d = dev_q;
    addr_d = addr_q;
    ready_d = ready_q;
    rvalid_d = 1'b0;
    done_d = 1'b0;
    nack_d = nack_q;
    rdata_d = rdata_q;
    case (state_q)
      host_por:
      begin
        if (wait_q == '0)
        begin
          state_d = host_idle;
          ready_d = 1'b1;
        end
        else
          wait_d = wait_q - WAIT_W'(1);
      end
      host_idle:
      begin
        if (cmd_valid && ready_q)
        begin
          ready_d = 1'b0;
          kind_d = cmd_kind;
          dev_d = cmd_dev;
          addr_d = cmd_addr;
          left_d = (cmd_len == 8'h00) ? 8'h01 : cmd_len;
          nack_d = 1'b0;
          step_d = (cmd_kind == read_random) ? 3'h0 : 3'h3;
          state_d = host_start;
          q_d = 2'h0;
        end
      end
      host_start:
      begin
        if (tick)
        begin
          q_d = q_q + 2'h1;
          if (q_q == 2'h3)
          begin
            state_d = host_bit;
            bit_d = 4'h0;
            tx_d = step_byte(step_q, dev_q, addr_q);
          end
        end
      end
      host_bit:
      begin
        if (tick)
        begin
          q_d = q_q + 2'h1;
          if (q_q == 2'h2)
          begin
            if (bit_q < 4'h8)
              rx_d = {rx_q[6:0], sda_q};
            else
              ackn_d = sda_q;
          end
          else if (q_q == 2'h3)
          begin
            if (bit_q < 4'h8)
            begin
              bit_d = bit_q + 4'h1;
              tx_d = {tx_q[6:0], 1'b0};
            end
            else
            begin
              bit_d = 4'h0;
              if (step_q == 3'h4)
              begin
                rvalid_d = 1'b1;
                rdata_d = rx_q;
                left_d = left_q - 8'h01;
                if (left_q <= 8'h01)
                  state_d = host_stop;
              end
              else if (ackn_q)
              begin
                nack_d = 1'b1;
                state_d = host_stop;
              end
              else if (step_q == 3'h2)
              begin
                step_d = 3'h3;
                state_d = host_start;
              end
              else
              begin
                step_d = step_q + 3'h1;
                tx_d = step_byte(step_q + 3'h1, dev_q, addr_q);
              end
            end
          end
        end
      end
      host_stop:
      begin
        if (tick)
        begin
          q_d = q_q + 2'h1;
          if (q_q == 2'h3)
          begin
            state_d = host_free;
            wait_d = WAIT_W'(FREE_CYC);
            done_d = 1'b1;
          end
        end
      end
      default:
      begin
        if (wait_q == '0)
        begin
          state_d = host_idle;
          ready_d = 1'b1;
        end
        else
          wait_d = wait_q - WAIT_W'(1);
      end
    endcase
    // pull trails scl by a cycle: data never moves on an scl edge, so no false start or stop
    drv_lead = drive(state_d, q_d, bit_level(step_d, bit_d, tx_d, left_d));
    drv_lag = drive(state_q, q_q, bit_level(step_q, bit_q, tx_q, left_q));
    scl_d = drv_lead[1];
    oe_d = drv_lag[0];
  end

  // sequencer registers and the two-stage sync of the data line
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= host_por;
      kind_q <= read_current;
      div_q <= '0;
      q_q <= 2'h0;
      bit_q <= 4'h0;
      step_q <= 3'h0;
      left_q <= 8'h00;
      tx_q <= 8'h00;
      rx_q <= 8'h00;
      ackn_q <= 1'b1;
      wait_q <= WAIT_W'(POWER_CYC);
      dev_q <= 3'h0;
      addr_q <= '0;
      scl_q <= 1'b1;
      oe_q <= 1'b0;
      ready_q <= 1'b0;
      rvalid_q <= 1'b0;
      done_q <= 1'b0;
      nack_q <= 1'b0;
      rdata_q <= 8'h00;
      sda_meta_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      kind_q <= kind_d;
      div_q <= div_d;
      q_q <= q_d;
      bit_q <= bit_d;
      step_q <= step_d;
      left_q <= left_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      ackn_q <= ackn_d;
      wait_q <= wait_d;
      dev_q <= dev_d;
      addr_q <= addr_d;
      scl_q <= scl_d;
      oe_q <= oe_d;
      ready_q <= ready_d;
      rvalid_q <= rvalid_d;
      done_q <= done_d;
      nack_q <= nack_d;
      rdata_q <= rdata_d;
      sda_meta_q <= link.sda;
      sda_q <= sda_meta_q;
    end
  end

  assign link.scl = scl_q;
  assign link.sda_host_oe = oe_q;
  assign link.sda_host_o = 1'b0;
  assign cmd_ready = ready_q;
  assign rd_data = rdata_q;
  assign rd_valid = rvalid_q;
  assign done = done_q;
  assign nack = nack_q;
endmodule

// file: verif/serp_link_asserts.sv
// checker for the two-wire link between the bus controller and the eeprom target
// assumes the link signals are sampled on the core clock, which is much faster than scl
`timescale 1ns/100ps
module serp_link_asserts #(
  parameter int POWER_CYC = 2000,
  parameter int FREE_CYC = 26
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_host_oe,
  input wire logic sda_dev_oe
);
  logic scl_p_q, sda_p_q, rw_q, rw_d, first_q, first_d, stopped_q, stopped_d;
  logic [3:0] bit_q, bit_d, sh_q, sh_d;
  logic [1:0] byte_q, byte_d;
  logic [15:0] cnt_q, cnt_d;
  logic rise, start_w, stop_w;
  // line events; both lines are slow, so one core cycle of delay is harmless
  assign rise = scl & ~scl_p_q;
  assign start_w = scl & scl_p_q & sda_p_q & ~sda;
  assign stop_w = scl & scl_p_q & ~sda_p_q & sda;
  // bit and byte position inside a frame, idle time since the last stop
  always_comb
  begin
    bit_d = bit_q;
    byte_d = byte_q;
    rw_d = rw_q;
    sh_d = sh_q;
    cnt_d = (cnt_q == 16'hFFFF) ? cnt_q : cnt_q + 16'h0001;
    first_d = first_q & ~start_w;
    stopped_d = (stopped_q | stop_w) & ~start_w;
    if (stop_w)
      cnt_d = 16'h0000;
    if (start_w)
    begin
      bit_d = 4'h0;
      byte_d = 2'h0;
    end
    else if (rise)
    begin
      sh_d = {sh_q[2:0], sda};
      bit_d = (bit_q == 4'h9) ? 4'h1 : bit_q + 4'h1;
      if (bit_q == 4'h9 && byte_q != 2'h3)
        byte_d = byte_q + 2'h1;
      if (bit_q == 4'h7 && byte_q == 2'h0)
        rw_d = sda;
    end
  end
  // byte 3 at reset keeps the byte-0 checks quiet, and rw 0 the read checks, until the first start
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      bit_q <= 4'h0;
      byte_q <= 2'h3;
      rw_q <= 1'b0;
      sh_q <= 4'h0;
      cnt_q <= 16'h0000;
      first_q <= 1'b1;
      stopped_q <= 1'b0;
    end
    else
    begin
      scl_p_q <= scl;
      sda_p_q <= sda;
      bit_q <= bit_d;
      byte_q <= byte_d;
      rw_q <= rw_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      first_q <= first_d;
      stopped_q <= stopped_d;
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_start;
    start_w;
  endsequence
  sequence s_stop;
    stop_w;
  endsequence
  dev_edge_low_a: assert property ($changed(sda_dev_oe) |-> !scl)
    else $error("device data moved while clock high");
  reset_idle_a: assert property ($rose(reset_n) |-> scl && !sda_dev_oe && !sda_host_oe)
    else $error("link not idle at reset release");
  power_wait_a: assert property (start_w && first_q |-> cnt_q >= POWER_CYC)
    else $error("first start too soon after reset");
  bus_free_a: assert property (start_w && stopped_q |-> cnt_q >= FREE_CYC)
    else $error("bus free time too short");
  prefix_bits_a: assert property (rise && byte_q == 2'h0 && bit_q == 4'h4 |-> sh_q == 4'hA)
    else $error("device address prefix wrong");
  addr_ack_free_a: assert property (rise && byte_q == 2'h0 && bit_q == 4'h8 |-> !sda_host_oe)
    else $error("controller drove address ack slot");
  ctl_ack_slot_a: assert property (rise && rw_q && byte_q != 2'h0 && bit_q == 4'h8 |-> !sda_dev_oe)
    else $error("device drove controller ack slot");
  read_bits_own_a: assert property (rise && rw_q && byte_q != 2'h0 && bit_q < 4'h8 && bit_q != 4'h0
    |-> !sda_host_oe)
    else $error("controller drove read data bit");
  stop_release_a: assert property (s_stop |=> !sda_dev_oe [*4])
    else $error("device held data after stop");
  start_clock_a: assert property (s_start |-> ##[1:64] !scl)
    else $error("no clock after start");
endmodule

// file: verif/serial_eeprom_read_path_bench.sv
// bench: bus controller and eeprom target joined over the link, driven from the user sides
// assumes package, interface, both design ends and the checker are compiled first
`timescale 1ns/100ps
module serial_eeprom_read_path_bench;
  import serp_pkg::*;
  localparam int POWER_CYC = 40;
  localparam int FREE_CYC = 26;
  logic core_clk = 1'b0, reset_n = 1'b0, cmd_valid = 1'b0, load_valid = 1'b0;
  logic cmd_ready, rd_valid, done, nack, link_busy;
  logic [2:0] chip_select_pins = 3'h5, cmd_dev = 3'h0;
  logic [13:0] cmd_addr = 14'h0000, load_addr = 14'h0000, ctr = 14'h0000;
  logic [7:0] cmd_len = 8'h00, load_data = 8'h00, rd_data;
  logic [13:0] fa [8] = '{14'h0123, 14'h0124, 14'h3FFE, 14'h3FFF, 14'h0000, 14'h0001, 14'h0002, 14'h0003};
  serp_read_kind_type cmd_kind = read_current;
  int mismatches = 0, n_tests = 0, cyc = 0;
  serp_link_if link();
  serp_host #(.SCL_DIV(4), .POWER_CYC(POWER_CYC), .FREE_CYC(FREE_CYC)) serp_host_i (.link(link),
    .core_clk(core_clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind),
    .cmd_dev(cmd_dev), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .rd_data(rd_data), .rd_valid(rd_valid),
    .done(done), .nack(nack));
  serp_device serp_device_i (.link(link), .core_clk(core_clk), .reset_n(reset_n),
    .chip_select_pins(chip_select_pins), .load_valid(load_valid), .load_addr(load_addr),
    .load_data(load_data), .link_busy(link_busy));
  serp_link_asserts #(.POWER_CYC(POWER_CYC), .FREE_CYC(FREE_CYC)) serp_link_asserts_i (.core_clk(core_clk),
    .reset_n(reset_n), .scl(link.scl), .sda(link.sda), .sda_host_oe(link.sda_host_oe),
    .sda_dev_oe(link.sda_dev_oe));
  // 20 MHz core clock and a free cycle count
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;
  // array contents follow the address, so a wrong counter shows as wrong data
  function automatic logic [7:0] pat(input logic [13:0] a);
    return a[7:0] ^ {2'h0, a[13:8]} ^ 8'hC3;
  endfunction
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    if (mismatches == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // one command, bytes judged against the model counter; nk means no device answers
  task automatic run(input serp_read_kind_type k, input logic [2:0] dv, input logic [13:0] a,
    input logic [7:0] n, input logic nk);
    int got;
    int t;
    logic busy;
    logic [13:0] e;
    got = 0;
    t = 0;
    busy = 1'b0;
    e = (k == read_random) ? a : ctr;
    while (cmd_ready !== 1'b1 && t < 500)
    begin
      @(negedge core_clk);
      t++;
    end
    chk("ready_wait", 16'(cmd_ready), 16'h0001);
    cmd_valid = 1'b1;
    cmd_kind = k;
    cmd_dev = dv;
    cmd_addr = a;
    cmd_len = n;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    t = 0;
    while (done !== 1'b1 && t < 8000)
    begin
      @(posedge core_clk);
      #1;
      t++;
      if (link_busy === 1'b1)
        busy = 1'b1;
      if (rd_valid === 1'b1)
      begin
        chk("rd_data", 16'(rd_data), 16'(pat(e + got[13:0])));
        got++;
      end
    end
    chk("done_seen", 16'(done), 16'h0001);
    chk("count", 16'(got), nk ? 16'h0000 : 16'(n));
    chk("nack", 16'(nack), 16'(nk));
    if (!nk)
    begin
      chk("busy", 16'(busy), 16'h0001);
      ctr = e + {6'h00, n};
    end
    repeat (8) @(posedge core_clk);
    #1;
    chk("standby", 16'(link_busy), 16'h0000);
  endtask
  // fill during the power wait, then time how long the controller takes to become ready
  task automatic t_power;
    int r;
    r = cyc;
    foreach (fa[i])
    begin
      @(negedge core_clk);
      load_valid = 1'b1;
      load_addr = fa[i];
      load_data = pat(fa[i]);
    end
    @(negedge core_clk);
    load_valid = 1'b0;
    chk("ready_early", 16'(cmd_ready), 16'h0000);
    while (cmd_ready !== 1'b1 && cyc - r < 500)
      @(negedge core_clk);
    chk("power_wait", 16'(cyc - r inside {[POWER_CYC:POWER_CYC + 2]}), 16'h0001);
  endtask
  task automatic t_random;
    run(read_random, 3'h5, 14'h0123, 8'h01, 1'b0);
  endtask
  task automatic t_current;
    run(read_current, 3'h5, 14'h0000, 8'h01, 1'b0);
  endtask
  // sequential read across the top of the 14-bit array
  task automatic t_wrap;
    run(read_random, 3'h5, 14'h3FFE, 8'h04, 1'b0);
  endtask
  // each wrong select value differs from the pins in a single bit
  task automatic t_wrong;
    logic [2:0] wd [3] = '{3'h4, 3'h7, 3'h1};
    foreach (wd[i])
      run(read_current, wd[i], 14'h0000, 8'h01, 1'b1);
  endtask
  initial
  begin
    repeat (4) @(negedge core_clk);
    reset_n = 1'b1;
    t_power;
    t_random;
    t_current;
    t_wrap;
    t_current;
    t_wrong;
    t_current;
    tally_and_finish;
  end
  // the whole sequence needs well under 8000 cycles
  initial
  begin
    repeat (30000) @(posedge core_clk);
    mismatches++;
    tally_and_finish;
  end
endmodule
